// ---- core/sfe_defines.svh ----
// constants of the spi command front end: opcodes, status layout, counts
// assumes inclusion by bare name from the core files
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFE_OP_SET_WRITE_LATCH 8'h06
`define SFE_OP_CLEAR_WRITE_LATCH 8'h04
`define SFE_OP_STATUS_READ 8'h05
`define SFE_OP_STATUS_WRITE 8'h01
`define SFE_OP_MEMORY_READ 8'h03
`define SFE_OP_FAST_MEMORY_READ 8'h0b
`define SFE_OP_MEMORY_WRITE 8'h02
`define SFE_OP_SLEEP 8'hb9
`define SFE_OP_IDENTITY_READ 8'h9f

// ----------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------
`define SFE_ST_WRITE_FLAG_BIT 1
`define SFE_ST_BG_LSB_BIT 2
`define SFE_ST_BG_MSB_BIT 3
`define SFE_ST_GPE_BIT 7
`define SFE_ST_RESET 8'h00

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define SFE_ADDR_W 15
`define SFE_BIT_LAST 3'h7
`define SFE_SYNC_STAGES 2

`endif

// ---- core/sfe_front_end.sv ----
// spi slave command front end: framing, mode detection, opcode decode, write latch
// assumes spi pins arrive asynchronously; memory array sits outside on mem_* ports
`timescale 1ns/1ps
`include "sfe_defines.svh"

module sfe_front_end (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic cs_n_in,
   input wire logic sck_in,
   input wire logic si_in,
   output logic so_out,
   output logic so_oe_out,
   output logic [7:0] status_out,
   output logic mode3_out,
   output logic [`SFE_ADDR_W-1:0] mem_addr_out,
   input wire logic [7:0] mem_rd_data_in,
   output logic [7:0] mem_wr_data_out,
   output logic mem_wr_strobe_out,
   output logic sleep_req_out,
   output logic identity_req_out
);

   // ----------------------------------------------------------------
   // pin synchronisers and edges
   // ----------------------------------------------------------------
   logic cs_n_s;
   logic sck_s;
   logic si_s;
   logic cs_n_d;
   logic sck_d;

   sfe_sync #(.W(3), .RESET_VAL(3'h4)) u_sync (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .pin_in({cs_n_in, sck_in, si_in}),
      .sync_out({cs_n_s, sck_s, si_s})
   );

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_n_d <= 1'b1;
         sck_d <= 1'b0;
      end else begin
         cs_n_d <= cs_n_s;
         sck_d <= sck_s;
      end
   end

   wire sel = !cs_n_s;
   wire cs_fall = cs_n_d && !cs_n_s;
   wire cs_rise = !cs_n_d && cs_n_s;
   wire sck_rise = !sck_d && sck_s;
   wire sck_fall = sck_d && !sck_s;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sfe_pkg::sfe_state_t state;
   sfe_pkg::sfe_state_t next_state;
   logic armed;
   logic [2:0] bit_cnt;
   logic byte_cnt;
   logic [7:0] rx;
   logic [7:0] opcode;
   logic [2:0] tx_cnt;
   logic write_enable_flag;
   logic guard_pin_enable;
   logic block_guard_msb;
   logic block_guard_lsb;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic sfe_pkg::sfe_state_t decode_op(input logic [7:0] op);
      sfe_pkg::sfe_state_t s;
      case (op)
         `SFE_OP_SET_WRITE_LATCH: s = sfe_pkg::sfe_st_done;
         `SFE_OP_CLEAR_WRITE_LATCH: s = sfe_pkg::sfe_st_done;
         `SFE_OP_SLEEP: s = sfe_pkg::sfe_st_done;
         `SFE_OP_IDENTITY_READ: s = sfe_pkg::sfe_st_done;
         `SFE_OP_STATUS_READ: s = sfe_pkg::sfe_st_status_rd;
         `SFE_OP_STATUS_WRITE: s = sfe_pkg::sfe_st_status_wr;
         `SFE_OP_MEMORY_READ: s = sfe_pkg::sfe_st_addr;
         `SFE_OP_FAST_MEMORY_READ: s = sfe_pkg::sfe_st_addr;
         `SFE_OP_MEMORY_WRITE: s = sfe_pkg::sfe_st_addr;
         default: s = sfe_pkg::sfe_st_ignore;
      endcase
      return s;
   endfunction

   // input is taken only while selected, armed and not discarding
   wire listening = (state != sfe_pkg::sfe_st_ignore) && (state != sfe_pkg::sfe_st_done);
   wire rx_take = sel && sck_rise && armed && listening;
   wire byte_done = rx_take && (bit_cnt == `SFE_BIT_LAST);
   wire [7:0] rx_byte = {rx[6:0], si_s};
   wire opcode_done = byte_done && (state == sfe_pkg::sfe_st_opcode);
   wire sending = (state == sfe_pkg::sfe_st_status_rd) || (state == sfe_pkg::sfe_st_read_data);
   wire [7:0] out_byte = (state == sfe_pkg::sfe_st_status_rd) ? status_out : mem_rd_data_in;
   wire tx_step = sel && sck_fall && sending;
   wire op_complete = (state != sfe_pkg::sfe_st_opcode) && (state != sfe_pkg::sfe_st_ignore);
   wire whole_bytes = (bit_cnt == 3'h0);
   wire ends_write = (opcode == `SFE_OP_CLEAR_WRITE_LATCH) || (opcode == `SFE_OP_STATUS_WRITE) ||
      (opcode == `SFE_OP_MEMORY_WRITE);
   wire flag_set = cs_rise && op_complete && whole_bytes && (opcode == `SFE_OP_SET_WRITE_LATCH);
   wire flag_clr = cs_rise && op_complete && whole_bytes && ends_write;
   wire status_wr = byte_done && (state == sfe_pkg::sfe_st_status_wr) && write_enable_flag;
   wire mem_wr = byte_done && (state == sfe_pkg::sfe_st_write_data) && write_enable_flag;

   always_comb begin
      next_state = state;
      if (byte_done) begin
         case (state)
            sfe_pkg::sfe_st_opcode: begin
               next_state = decode_op(rx_byte);
            end
            sfe_pkg::sfe_st_addr: begin
               if (byte_cnt) begin
                  if (opcode == `SFE_OP_MEMORY_WRITE) begin
                     next_state = sfe_pkg::sfe_st_write_data;
                  end else if (opcode == `SFE_OP_FAST_MEMORY_READ) begin
                     next_state = sfe_pkg::sfe_st_dummy;
                  end else begin
                     next_state = sfe_pkg::sfe_st_read_data;
                  end
               end
            end
            sfe_pkg::sfe_st_dummy: begin
               next_state = sfe_pkg::sfe_st_read_data;
            end
            sfe_pkg::sfe_st_status_wr: begin
               next_state = sfe_pkg::sfe_st_done;
            end
            default: begin
               next_state = state;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // framing and receive
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= sfe_pkg::sfe_st_opcode;
         bit_cnt <= 3'h0;
         byte_cnt <= 1'b0;
         armed <= 1'b0;
         mode3_out <= 1'b0;
      end else if (cs_fall) begin
         state <= sfe_pkg::sfe_st_opcode;
         bit_cnt <= 3'h0;
         byte_cnt <= 1'b0;
         armed <= !sck_s;
         mode3_out <= sck_s;
      end else begin
         state <= next_state;
         if (rx_take) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (byte_done && (state == sfe_pkg::sfe_st_addr)) begin
            byte_cnt <= !byte_cnt;
         end
         if (sel && sck_fall) begin
            armed <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx <= 8'h00;
         opcode <= 8'h00;
      end else begin
         if (rx_take) begin
            rx <= rx_byte;
         end
         if (cs_fall) begin
            opcode <= 8'h00;
         end else if (opcode_done) begin
            opcode <= rx_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // address and memory strobes
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_addr_out <= '0;
      end else if (byte_done && (state == sfe_pkg::sfe_st_addr)) begin
         if (!byte_cnt) begin
            mem_addr_out <= {rx_byte[6:0], mem_addr_out[7:0]};
         end else begin
            mem_addr_out <= {mem_addr_out[14:8], rx_byte};
         end
      end else if (mem_wr_strobe_out) begin
         mem_addr_out <= mem_addr_out + 15'h0001;
      end else if (tx_step && (tx_cnt == `SFE_BIT_LAST) && (state == sfe_pkg::sfe_st_read_data)) begin
         mem_addr_out <= mem_addr_out + 15'h0001;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_wr_data_out <= 8'h00;
         mem_wr_strobe_out <= 1'b0;
         sleep_req_out <= 1'b0;
         identity_req_out <= 1'b0;
      end else begin
         mem_wr_strobe_out <= mem_wr;
         if (mem_wr) begin
            mem_wr_data_out <= rx_byte;
         end
         sleep_req_out <= opcode_done && (rx_byte == `SFE_OP_SLEEP);
         identity_req_out <= opcode_done && (rx_byte == `SFE_OP_IDENTITY_READ);
      end
   end

   // ----------------------------------------------------------------
   // transmit on falling clock
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_cnt <= 3'h0;
         so_out <= 1'b0;
      end else if (cs_fall) begin
         tx_cnt <= 3'h0;
         so_out <= 1'b0;
      end else if (tx_step) begin
         so_out <= out_byte[3'h7 - tx_cnt];
         tx_cnt <= tx_cnt + 3'h1;
      end
   end

   assign so_oe_out = sel && sending;

   // ----------------------------------------------------------------
   // write latch and status register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         write_enable_flag <= 1'b0;
      end else if (flag_set) begin
         write_enable_flag <= 1'b1;
      end else if (flag_clr) begin
         write_enable_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         guard_pin_enable <= 1'b0;
         block_guard_msb <= 1'b0;
         block_guard_lsb <= 1'b0;
      end else if (status_wr) begin
         guard_pin_enable <= rx_byte[`SFE_ST_GPE_BIT];
         block_guard_msb <= rx_byte[`SFE_ST_BG_MSB_BIT];
         block_guard_lsb <= rx_byte[`SFE_ST_BG_LSB_BIT];
      end
   end

   // fixed zeros at bits 0 and 4..6
   assign status_out = {guard_pin_enable, 3'h0, block_guard_msb, block_guard_lsb, write_enable_flag, 1'b0};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   a_deselect_tristate: assert property (cs_n_s |-> !so_oe_out)
      else $error("serial output driven while deselected");
   a_frame_restart: assert property (cs_fall |=> (bit_cnt == 3'h0) && (state == sfe_pkg::sfe_st_opcode))
      else $error("frame did not restart at select fall");
   a_mode_capture: assert property (cs_fall |=> (mode3_out == $past(sck_s)) && (armed != $past(sck_s)))
      else $error("mode not taken from clock level at select");
   a_mode3_wait: assert property (sel && !armed && sck_rise && !cs_fall |=> $stable(bit_cnt))
      else $error("mode 3 counted a rise before the clock toggled");
   a_opcode_first: assert property (opcode_done |=> (opcode == $past(rx_byte)) && (state != sfe_pkg::sfe_st_opcode))
      else $error("first byte not taken as opcode");
   a_invalid_hold: assert property (sel && (state == sfe_pkg::sfe_st_ignore) && !cs_fall |=>
      (state == sfe_pkg::sfe_st_ignore) && !so_oe_out && $stable(bit_cnt))
      else $error("input not ignored after unknown opcode");
   a_latch_set: assert property (flag_set |=> write_enable_flag ##0 status_out[1])
      else $error("latch set opcode did not set latch");
   a_latch_clear: assert property (flag_clr |=> !write_enable_flag ##0 !status_out[1])
      else $error("latch not cleared at select rise");
   a_partial_keep: assert property (cs_rise && !whole_bytes |=> $stable(write_enable_flag))
      else $error("partial byte changed the latch");
   a_status_keeps_flag: assert property (status_wr |=> $stable(write_enable_flag))
      else $error("status write touched the latch flag");
   a_status_zeros: assert property ((status_out[0] == 1'b0) && (status_out[6:4] == 3'h0))
      else $error("fixed status bits not zero");

   c_status_read: cover property (tx_step && (state == sfe_pkg::sfe_st_status_rd) && (tx_cnt == 3'h7));
   c_latch_set: cover property (flag_set);
   c_mem_write: cover property (mem_wr);
   c_invalid_op: cover property (opcode_done && (decode_op(rx_byte) == sfe_pkg::sfe_st_ignore));

endmodule

// ---- core/sfe_pkg.sv ----
// types of the spi command front end
// assumes nothing beyond a systemverilog compiler
package sfe_pkg;

   // ----------------------------------------------------------------
   // frame states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      sfe_st_opcode,
      sfe_st_addr,
      sfe_st_dummy,
      sfe_st_read_data,
      sfe_st_write_data,
      sfe_st_status_rd,
      sfe_st_status_wr,
      sfe_st_done,
      sfe_st_ignore
   } sfe_state_t;

endpackage

// ---- core/sfe_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
// assumes asynchronous pins and one core clock
`timescale 1ns/1ps
module sfe_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);

   // ----------------------------------------------------------------
   // stages
   // ----------------------------------------------------------------
   logic [W-1:0] meta;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta <= pin_in;
         sync_out <= meta;
      end
   end

endmodule

// ---- dv/sfe_spi_master.sv ----
// spi master model: drives select, serial clock and serial input of the front end
// assumes the core clock as time base; one serial clock half period is 8 core cycles
`timescale 1ns/1ps
module sfe_spi_master (
   input wire logic clk_in,
   input wire logic so_in,
   output logic cs_n_out,
   output logic sck_out,
   output logic si_out
);
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
   end

   // ----------------------------------------------------------------
   // pin timing
   // ----------------------------------------------------------------
   task automatic half();
      repeat (8) @(posedge clk_in);
      #1;
   endtask

   // n bits of tx, msb first; so taken just before each rise
   task automatic shift(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b0;
         si_out = tx[63-i];
         half();
         rx = {rx[62:0], so_in};
         sck_out = 1'b1;
         half();
      end
   endtask

   // one select period with the clock parked per mode
   task automatic frame(input logic m3, input logic [63:0] tx, input int n, output logic [63:0] rx);
      sck_out = m3;
      half();
      cs_n_out = 1'b0;
      half();
      shift(tx, n, rx);
      sck_out = m3;
      half();
      cs_n_out = 1'b1;
      si_out = ~si_out;
      half();
   endtask
endmodule

// ---- dv/testbench.sv ----
// self-checking bench of the spi command front end
// assumes the spi master model and a combinational memory read pattern
`timescale 1ns/1ps
module testbench;
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   logic so_out;
   logic so_oe_out;
   wire logic so_line;
   logic mode3_out;
   logic mem_wr_strobe_out;
   logic sleep_req_out;
   logic identity_req_out;
   logic [7:0] status_out;
   logic [7:0] mem_wr_data_out;
   logic [7:0] mem_rd_data;
   logic [14:0] mem_addr_out;
   logic [63:0] rx;
   logic [22:0] wr_log[$];
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int sleeps = 0;
   int idents = 0;
   int oe_seen = 0;

   // ----------------------------------------------------------------
   // clock, memory pattern, instances
   // ----------------------------------------------------------------
   always #2.5 core_clk_in = ~core_clk_in;
   assign mem_rd_data = mem_addr_out[7:0] ^ 8'ha5;
   // released output shows the inverse of its last value
   assign so_line = so_oe_out ? so_out : !so_out;

   sfe_front_end uut (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .cs_n_in(cs_n),
      .sck_in(sck),
      .si_in(si),
      .so_out(so_out),
      .so_oe_out(so_oe_out),
      .status_out(status_out),
      .mode3_out(mode3_out),
      .mem_addr_out(mem_addr_out),
      .mem_rd_data_in(mem_rd_data),
      .mem_wr_data_out(mem_wr_data_out),
      .mem_wr_strobe_out(mem_wr_strobe_out),
      .sleep_req_out(sleep_req_out),
      .identity_req_out(identity_req_out)
   );

   sfe_spi_master master (
      .clk_in(core_clk_in),
      .so_in(so_line),
      .cs_n_out(cs_n),
      .sck_out(sck),
      .si_out(si)
   );

   // ----------------------------------------------------------------
   // monitors and timeout
   // ----------------------------------------------------------------
   always @(posedge core_clk_in) begin
      cycles++;
      if (mem_wr_strobe_out === 1'b1) begin
         wr_log.push_back({mem_addr_out, mem_wr_data_out});
      end
      if (sleep_req_out === 1'b1) begin
         sleeps++;
      end
      if (identity_req_out === 1'b1) begin
         idents++;
      end
      if (so_oe_out !== 1'b0) begin
         oe_seen++;
      end
      if (cycles == 40000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic xf(input logic m3, input logic [63:0] tx, input int n);
      master.frame(m3, tx, n, rx);
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk_in);
      #1;
      resetn_in = 1'b1;
      repeat (4) @(posedge core_clk_in);
      #1;
      chk(23'(status_out), 23'h00, "status after reset");
      chk(23'(so_oe_out), 23'h0, "so enable idle");
      oe_seen = 0;
      xf(1'b0, {8'h05, 56'h0}, 24);
      chk(rx[22:0], {7'h7f, 16'h0000}, "status read");
      chk(23'(oe_seen != 0), 23'h1, "so enabled in status read");
      xf(1'b1, {8'h06, 56'h0}, 8);
      chk(23'(status_out), 23'h02, "latch set");
      chk(23'(mode3_out), 23'h1, "mode 3 seen");
      xf(1'b1, {8'h05, 56'h0}, 16);
      chk(rx[22:0], 23'h00ff02, "status read mode 3");
      xf(1'b0, {8'h01, 8'hff, 48'h0}, 16);
      chk(23'(status_out), 23'h8c, "status write");
      chk(23'(mode3_out), 23'h0, "mode 0 seen");
      xf(1'b0, {8'h02, 8'hff, 8'hfe, 8'h3c, 8'h5a, 8'h96, 16'h0}, 48);
      chk(23'(wr_log.size()), 23'h0, "write refused");
      xf(1'b0, {8'h06, 56'h0}, 8);
      xf(1'b0, {8'h02, 8'hff, 8'hfe, 8'h3c, 8'h5a, 8'h96, 16'h0}, 48);
      chk(23'(wr_log.size()), 23'h3, "write count");
      chk(wr_log[0], {15'h7ffe, 8'h3c}, "write byte 0");
      chk(wr_log[1], {15'h7fff, 8'h5a}, "write byte 1");
      chk(wr_log[2], {15'h0000, 8'h96}, "write wrap");
      chk(23'(status_out), 23'h8c, "latch after write");
      xf(1'b0, {8'h03, 8'h00, 8'h10, 40'h0}, 40);
      chk(rx[22:0], {7'h7f, 8'hb5, 8'hb4}, "memory read");
      xf(1'b1, {8'h0b, 8'h00, 8'h20, 8'h00, 32'h0}, 48);
      chk(rx[22:0], {7'h7f, 8'h85, 8'h84}, "fast read");
      xf(1'b0, {8'h06, 56'h0}, 8);
      chk(23'(status_out), 23'h8e, "latch set again");
      xf(1'b0, {8'h04, 56'h0}, 8);
      chk(23'(status_out), 23'h8c, "latch clear");
      oe_seen = 0;
      xf(1'b0, {8'hc3, 8'h06, 8'h05, 40'h0}, 32);
      chk(23'(status_out), 23'h8c, "unknown opcode");
      chk(23'(oe_seen), 23'h0, "unknown opcode so");
      xf(1'b0, {8'h06, 8'h05, 48'h0}, 24);
      chk(23'(status_out), 23'h8e, "fresh frame");
      chk(23'(oe_seen), 23'h0, "second opcode ignored");
      xf(1'b0, {8'h02, 8'hff, 8'hfe, 8'h11, 32'h0}, 28);
      chk(23'(status_out), 23'h8e, "partial byte");
      chk(23'(wr_log.size()), 23'h3, "partial no strobe");
      master.shift({8'h04, 56'h0}, 8, rx);
      chk(23'(status_out), 23'h8e, "deselected input");
      chk(23'(oe_seen), 23'h0, "deselected so");
      xf(1'b0, {8'hb9, 56'h0}, 8);
      xf(1'b1, {8'h9f, 56'h0}, 8);
      chk(23'(sleeps), 23'h1, "sleep request");
      chk(23'(idents), 23'h1, "identity request");
      chk(23'(oe_seen), 23'h0, "single byte so");
      report_and_stop();
   end
endmodule
